// >>> rtl/rxfc_pause_filter.sv
// receive pause frame filter with its register file and input fifo
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_defines.svh"

// ==========================================================================
// fifo
module rxfc_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  output logic                  rd_valid_out,
  output logic      [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  // pointers carry one spare bit so a full buffer differs from an empty one
  assign wr_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign rd_valid_out = wr_ptr != rd_ptr;
  assign rd_data_out  = mem[rd_ptr[AW-1:0]];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (do_wr)
    begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (do_rd)
      begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule

// ==========================================================================
// pause filter top
module rxfc_pause_filter #(
  parameter int          CLASSES    = 8,
  parameter bit          PRIORITY   = 1'b1,
  parameter int          FIFO_DEPTH = 16,
  parameter logic [31:0] REVISION   = 32'h00010000, // arbitrary value
  parameter logic [31:0] VARIANT0   = 32'h61626364, // arbitrary value
  parameter logic [31:0] VARIANT1   = 32'h65666768, // arbitrary value
  parameter logic [31:0] VARIANT2   = 32'h696a6b6c  // arbitrary value
) (
  input  wire logic               clk_sys_in,
  input  wire logic               nrst_in,
  input  wire logic [11:0]        reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [31:0]        reg_rdata_out,
  input  wire logic               rx_valid_in,
  input  wire logic [63:0]        rx_data_in,
  input  wire logic               rx_sop_in,
  input  wire logic               rx_eop_in,
  output logic                    rx_ready_out,
  output logic                    client_valid_out,
  output logic      [63:0]        client_data_out,
  output logic                    client_sop_out,
  output logic                    client_eop_out,
  input  wire logic               client_ready_in,
  output logic                    pause_notify_out,
  output logic      [CLASSES-1:0] pause_class_out
);
  import rxfc_pkg::*;

  // ========================================================================
  // registers
  logic [31:0]        rx_fc_scratch;
  logic [CLASSES-1:0] pause_class_enable;
  logic               matched_pause_forward;
  logic [31:0]        pause_match_addr_low;
  logic [15:0]        pause_match_addr_high;
  logic               tx_pause_honour_enable;
  logic [15:0]        processed_count;
  logic [7:0]         last_class;
  logic [31:0]        next_rdata;

  // writes to read-only or unmapped offsets fall through to the default and change nothing
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_fc_scratch          <= `RXFC_RST_SCRATCH;
      pause_class_enable     <= '1;
      matched_pause_forward  <= `RXFC_RST_FORWARD;
      pause_match_addr_low   <= `RXFC_RST_ADDR_LOW;
      pause_match_addr_high  <= `RXFC_RST_ADDR_HIGH;
      tx_pause_honour_enable <= `RXFC_RST_HONOUR;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `RXFC_OFF_SCRATCH:   rx_fc_scratch <= reg_wdata_in;
        `RXFC_OFF_ENABLE:    pause_class_enable <= reg_wdata_in[CLASSES-1:0];
        `RXFC_OFF_FORWARD:   matched_pause_forward <= reg_wdata_in[0];
        `RXFC_OFF_ADDR_LOW:  pause_match_addr_low <= reg_wdata_in;
        `RXFC_OFF_ADDR_HIGH: pause_match_addr_high <= reg_wdata_in[15:0];
        `RXFC_OFF_HONOUR:    tx_pause_honour_enable <= reg_wdata_in[0];
        default:             ;
      endcase
    end
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    case (reg_addr_in)
      `RXFC_OFF_REVISION:  next_rdata = REVISION;
      `RXFC_OFF_SCRATCH:   next_rdata = rx_fc_scratch;
      `RXFC_OFF_VARIANT0:  next_rdata = VARIANT0;
      `RXFC_OFF_VARIANT1:  next_rdata = VARIANT1;
      `RXFC_OFF_VARIANT2:  next_rdata = VARIANT2;
      `RXFC_OFF_ENABLE:    next_rdata[CLASSES-1:0] = pause_class_enable;
      `RXFC_OFF_FORWARD:   next_rdata[0] = matched_pause_forward;
      `RXFC_OFF_ADDR_LOW:  next_rdata = pause_match_addr_low;
      `RXFC_OFF_ADDR_HIGH: next_rdata[15:0] = pause_match_addr_high;
      `RXFC_OFF_STATUS:    next_rdata = {processed_count, 8'h00, last_class};
      `RXFC_OFF_HONOUR:    next_rdata[0] = tx_pause_honour_enable;
      default:             next_rdata = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out <= 32'h00000000;
    end
    else
    begin
      reg_rdata_out <= reg_rd_in ? next_rdata : 32'h00000000;
    end
  end

  // ========================================================================
  // input fifo: {sop, eop, data}
  logic        f_valid;
  logic [65:0] f_word;
  logic        f_pop;

  rxfc_fifo #(
    .WIDTH (66),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (rx_valid_in),
    .wr_data_in   ({rx_sop_in, rx_eop_in, rx_data_in}),
    .wr_ready_out (rx_ready_out),
    .rd_valid_out (f_valid),
    .rd_data_out  (f_word),
    .rd_ready_in  (f_pop)
  );

  // ========================================================================
  // header hold and decision
  // the first three words are held back so a matched frame can be dropped whole
  rxfc_state_t        state;
  logic [65:0]        hdr [0:2];
  logic [1:0]         hcnt;
  logic [1:0]         eidx;
  logic               drop;
  logic               out_can;
  logic               push;
  logic [65:0]        push_word;
  logic               decide;
  logic               is_pause;
  logic               addr_match;
  logic [CLASSES-1:0] frame_class;
  logic [CLASSES-1:0] act_class;
  logic               notify;

  assign out_can = !client_valid_out || client_ready_in;
  assign decide  = (state == RXFC_ST_HDR) && f_valid && (f_word[64] || hcnt == 2'h2);

  // too short frames never qualify as pause frames
  assign is_pause = (hcnt == 2'h2) && hdr[1][31:16] == `RXFC_ETYPE_MACCTRL &&
                    hdr[1][15:0] == (PRIORITY ? `RXFC_OPC_PFC : `RXFC_OPC_STD);
  assign addr_match  = hdr[0][63:16] == {pause_match_addr_high, pause_match_addr_low};
  assign frame_class = PRIORITY ? f_word[CLASSES+47:48] : CLASSES'(1);
  assign act_class   = PRIORITY ? (frame_class & pause_class_enable)
                                : {{(CLASSES-1){1'b0}}, pause_class_enable[0]};
  // judged on the third word, where the class vector arrives; one pulse per frame
  assign notify = decide && is_pause && addr_match && (act_class != '0) &&
                  (PRIORITY || tx_pause_honour_enable);

  always_comb
  begin
    f_pop     = 1'b0;
    push      = 1'b0;
    push_word = f_word;
    case (state)
      RXFC_ST_HDR:
      begin
        // header words are collected, nothing leaves yet
        f_pop = 1'b1;
      end
      RXFC_ST_EMIT:
      begin
        // a dropped frame still walks its held words so the counts stay aligned
        push      = !drop && out_can;
        push_word = hdr[eidx];
      end
      RXFC_ST_BODY:
      begin
        f_pop = drop || out_can;
        push  = !drop && out_can && f_valid;
      end
      default:
      begin
        f_pop = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= RXFC_ST_HDR;
      hcnt  <= 2'h0;
      eidx  <= 2'h0;
      drop  <= 1'b0;
    end
    else
    begin
      case (state)
        RXFC_ST_HDR:
        begin
          if (f_valid)
          begin
            hcnt <= hcnt + 2'h1;
            if (decide)
            begin
              drop  <= is_pause && addr_match && !matched_pause_forward;
              eidx  <= 2'h0;
              state <= RXFC_ST_EMIT;
            end
          end
        end
        RXFC_ST_EMIT:
        begin
          if (drop || out_can)
          begin
            eidx <= eidx + 2'h1;
            if (eidx + 2'h1 == hcnt)
            begin
              hcnt  <= 2'h0;
              // a frame that ended inside the held words goes straight back to collecting
              state <= hdr[eidx][64] ? RXFC_ST_HDR : RXFC_ST_BODY;
            end
          end
        end
        RXFC_ST_BODY:
        begin
          if (f_valid && f_pop && f_word[64])
          begin
            state <= RXFC_ST_HDR;
          end
        end
        default: state <= RXFC_ST_HDR;
      endcase
    end
  end

  // hcnt stays below 3 while collecting, so the index never leaves the array
  always_ff @(posedge clk_sys_in)
  begin
    if (state == RXFC_ST_HDR && f_valid)
    begin
      hdr[hcnt] <= f_word;
    end
  end

  // ========================================================================
  // client output and pause notification
  // a new word loads only into an empty or draining slot, so a stalled word is never lost
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      client_valid_out <= 1'b0;
      client_data_out  <= 64'h0000000000000000;
      client_sop_out   <= 1'b0;
      client_eop_out   <= 1'b0;
    end
    else if (push)
    begin
      client_valid_out <= 1'b1;
      client_sop_out   <= push_word[65];
      client_eop_out   <= push_word[64];
      client_data_out  <= push_word[63:0];
    end
    else if (client_ready_in)
    begin
      client_valid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pause_notify_out <= 1'b0;
      pause_class_out  <= '0;
      processed_count  <= 16'h0000;
      last_class       <= 8'h00;
    end
    else
    begin
      pause_notify_out <= notify;
      if (notify)
      begin
        pause_class_out <= act_class;
        // the count wraps; it is a debug aid, not a statistics counter
        processed_count <= processed_count + 16'h0001;
        last_class      <= 8'(act_class);
      end
    end
  end
endmodule
`default_nettype wire

// >>> inc/rxfc_defines.svh
// register offsets, reset values and frame constants of the receive pause filter
`ifndef RXFC_DEFINES_SVH
`define RXFC_DEFINES_SVH
`define RXFC_ADDR_W        12
`define RXFC_OFF_REVISION  12'h700
`define RXFC_OFF_SCRATCH   12'h701
`define RXFC_OFF_VARIANT0  12'h702
`define RXFC_OFF_VARIANT1  12'h703
`define RXFC_OFF_VARIANT2  12'h704
`define RXFC_OFF_ENABLE    12'h705
`define RXFC_OFF_FORWARD   12'h706
`define RXFC_OFF_ADDR_LOW  12'h707
`define RXFC_OFF_ADDR_HIGH 12'h708
`define RXFC_OFF_STATUS    12'h709
`define RXFC_OFF_HONOUR    12'h70a
`define RXFC_RST_SCRATCH   32'h00000000
`define RXFC_RST_ADDR_LOW  32'hc2000001
`define RXFC_RST_ADDR_HIGH 16'h0180
`define RXFC_RST_FORWARD   1'h0
`define RXFC_RST_HONOUR    1'h1
`define RXFC_ETYPE_MACCTRL 16'h8808
`define RXFC_OPC_STD       16'h0001
`define RXFC_OPC_PFC       16'h0101
`define RXFC_HDR_WORDS     2'h3
`endif

// >>> inc/rxfc_pkg.sv
// types shared by the receive pause filter
`default_nettype none
package rxfc_pkg;
  typedef enum logic [2:0] {
    RXFC_ST_HDR  = 3'b001,
    RXFC_ST_EMIT = 3'b010,
    RXFC_ST_BODY = 3'b100
  } rxfc_state_t;
endpackage
`default_nettype wire

// >>> test/rxfc_pause_filter_chk.sv
// port checker of the receive pause filter
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module rxfc_pause_filter_chk #(
  parameter int          CLASSES  = 8,
  parameter logic [31:0] REVISION = 32'h0
) (
  input wire logic               clk_sys_in,
  input wire logic               nrst_in,
  input wire logic [11:0]        reg_addr_in,
  input wire logic [31:0]        reg_wdata_in,
  input wire logic               reg_wr_in,
  input wire logic               reg_rd_in,
  input wire logic [31:0]        reg_rdata_out,
  input wire logic               rx_ready_out,
  input wire logic               client_valid_out,
  input wire logic [63:0]        client_data_out,
  input wire logic               client_sop_out,
  input wire logic               client_eop_out,
  input wire logic               client_ready_in,
  input wire logic               pause_notify_out,
  input wire logic [CLASSES-1:0] pause_class_out
);
  logic [31:0] scratch;
  logic        in_frame;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // shadow of the scratch word so read-back is judged against the writes
  always_ff @(posedge clk_sys_in or negedge nrst_in)
    if (!nrst_in)
      scratch <= 32'h0;
    else if (reg_wr_in && reg_addr_in == 12'h701)
      scratch <= reg_wdata_in;
  always_ff @(posedge clk_sys_in or negedge nrst_in)
    if (!nrst_in)
      in_frame <= 1'b0;
    else if (client_valid_out && client_ready_in)
      in_frame <= !client_eop_out;
  a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside answer cycle");
  a_revision_fixed: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 12'h700
    |-> reg_rdata_out == REVISION)
    else $error("revision word wrong");
  a_scratch_readback: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 12'h701
    |-> reg_rdata_out == scratch)
    else $error("scratch read-back wrong");
  a_notify_one_pulse: assert property (pause_notify_out |=> !pause_notify_out)
    else $error("notify longer than one cycle");
  a_class_held_between: assert property (!pause_notify_out |-> $stable(pause_class_out))
    else $error("class vector moved without notify");
  a_notify_has_class: assert property (pause_notify_out |-> pause_class_out != '0)
    else $error("notify with empty class vector");
  a_client_word_held: assert property (client_valid_out && !client_ready_in
    |=> client_valid_out && $stable(client_data_out))
    else $error("client word dropped while stalled");
  a_client_frame_order: assert property (client_valid_out |-> client_sop_out == !in_frame)
    else $error("client frame start out of order");
  c_notify: cover property (pause_notify_out);
  c_buffer_full: cover property (!rx_ready_out);
  c_client_stall: cover property (client_valid_out && !client_ready_in);
endmodule
bind rxfc_pause_filter rxfc_pause_filter_chk #(.CLASSES(CLASSES), .REVISION(REVISION)) u_chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_ready_out(rx_ready_out),
  .client_valid_out(client_valid_out), .client_data_out(client_data_out), .client_sop_out(client_sop_out),
  .client_eop_out(client_eop_out), .client_ready_in(client_ready_in), .pause_notify_out(pause_notify_out),
  .pause_class_out(pause_class_out));
`default_nettype wire

// >>> test/rxfc_link_peer.sv
// link peer model sending frames into the receive stream
`timescale 1ns/1ps
`default_nettype none
// ====
// peer
module rxfc_link_peer (
  input  wire logic   clk_sys_in,
  input  wire logic   ready_in,
  output var logic        valid_out = 1'b0,
  output var logic [63:0] data_out = 64'h0,
  output var logic        sop_out = 1'b0,
  output var logic        eop_out = 1'b0
);
  // released data shows the inverse of the last word, never a stale copy
  task automatic idle();
    valid_out <= 1'b0;
    data_out  <= ~data_out;
    sop_out   <= 1'b0;
    eop_out   <= 1'b0;
  endtask
  // gap above zero makes the peer slow between words
  task automatic send(input logic [47:0] da, input logic [31:0] typ, input logic [7:0] cls, input int gap);
    logic [63:0] w [4];
    w = '{{da, 16'h0a0b}, {32'h0c0d0e0f, typ}, {8'h00, cls, 48'h0}, 64'h1234};
    for (int i = 0; i < 4; i++)
    begin
      if (gap > 0 && i > 0)
      begin
        idle();
        repeat (gap) @(posedge clk_sys_in);
      end
      valid_out <= 1'b1;
      data_out  <= w[i];
      sop_out   <= (i == 0);
      eop_out   <= (i == 3);
      do @(posedge clk_sys_in); while (!ready_in);
    end
    idle();
    // one idle edge between frames, so no signal is assigned twice in one step
    @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_rxfc_pause_filter.sv
// self-checking bench of the receive pause filter
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module tb_rxfc_pause_filter;
  typedef struct {
    logic [7:0] en; logic fwd; logic [47:0] da; logic [31:0] typ;
    logic [7:0] cls; int nfy; logic [7:0] ecls; int words;
  } rxfc_row_t;
  localparam logic [47:0] DA = 48'h0180c2000001;
  localparam logic [31:0] PF = 32'h88080101;
  // identity words are arbitrary
  localparam logic [31:0] REV = 32'h00000123, V0 = 32'h71727374, V1 = 32'h75767778, V2 = 32'h797a7b7c;
  rxfc_row_t rows [6] = '{
    '{8'hff, 1'b0, DA, PF, 8'h03, 1, 8'h03, 0},
    '{8'h0f, 1'b0, DA, PF, 8'h13, 1, 8'h03, 0},
    '{8'h0f, 1'b1, DA, PF, 8'h30, 0, 8'h03, 4},
    '{8'hff, 1'b1, DA, PF, 8'h81, 1, 8'h81, 4},
    '{8'hff, 1'b0, DA ^ 48'h1, PF, 8'h01, 0, 8'h81, 4},
    '{8'hff, 1'b0, DA, 32'h08000101, 8'h01, 0, 8'h81, 4}};
  logic        clk_sys_in, nrst_in, reg_wr_in, reg_rd_in, rx_valid_in, rx_sop_in, rx_eop_in, rx_ready_out;
  logic        client_valid_out, client_sop_out, client_eop_out, client_ready_in, pause_notify_out, std_notify_out;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [63:0] rx_data_in, client_data_out, sop_word, eop_word;
  logic [7:0]  pause_class_out, std_class_out;
  logic [31:0] rst_exp [12];
  int          fails, tests_run, n_notify, n_words, cycles, n0, w0, k, n_std;
  rxfc_pause_filter #(.REVISION(REV), .VARIANT0(V0), .VARIANT1(V1), .VARIANT2(V2)) u_dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_sop_in(rx_sop_in), .rx_eop_in(rx_eop_in), .rx_ready_out(rx_ready_out),
    .client_valid_out(client_valid_out), .client_data_out(client_data_out), .client_sop_out(client_sop_out),
    .client_eop_out(client_eop_out), .client_ready_in(client_ready_in), .pause_notify_out(pause_notify_out),
    .pause_class_out(pause_class_out));
  // standard-mode twin on the same stream and bus; only its notification is watched
  rxfc_pause_filter #(.PRIORITY(1'b0), .REVISION(REV), .VARIANT0(V0), .VARIANT1(V1), .VARIANT2(V2)) u_dut_std (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_sop_in(rx_sop_in), .rx_eop_in(rx_eop_in), .rx_ready_out(),
    .client_valid_out(), .client_data_out(), .client_sop_out(), .client_eop_out(),
    .client_ready_in(client_ready_in), .pause_notify_out(std_notify_out), .pause_class_out(std_class_out));
  rxfc_link_peer u_peer (.clk_sys_in(clk_sys_in), .ready_in(rx_ready_out), .valid_out(rx_valid_in),
    .data_out(rx_data_in), .sop_out(rx_sop_in), .eop_out(rx_eop_in));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk(64'(reg_rdata_out), 64'(exp));
    @(posedge clk_sys_in);
  endtask
  // client-side monitor and hang limit
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (pause_notify_out === 1'b1) n_notify++;
    if (client_valid_out === 1'b1 && client_ready_in) n_words++;
    if (client_valid_out === 1'b1 && client_ready_in && client_sop_out) sop_word = client_data_out;
    if (client_valid_out === 1'b1 && client_ready_in && client_eop_out) eop_word = client_data_out;
    if (std_notify_out === 1'b1) n_std++;
    if (cycles == 5000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    nrst_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 12'h0;
    reg_wdata_in = 32'h0;
    client_ready_in = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (rows[i])
    begin
      wr(12'h705, {24'h0, rows[i].en});
      wr(12'h706, {31'h0, rows[i].fwd});
      n0 = n_notify;
      w0 = n_words;
      u_peer.send(rows[i].da, rows[i].typ, rows[i].cls, i % 2);
      repeat (40) @(posedge clk_sys_in);
      chk(64'(n_notify - n0), 64'(rows[i].nfy));
      chk(64'(pause_class_out), 64'(rows[i].ecls));
      chk(64'(n_words - w0), 64'(rows[i].words));
      if (rows[i].words > 0) chk(64'(sop_word[63:16]), 64'(rows[i].da));
      if (rows[i].words > 0) chk(eop_word, 64'h1234);
    end
    $display("frame rows done");
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    rst_exp = '{REV, 0, V0, V1, V2, 32'hff, 0, 32'hc2000001, 32'h180, 0, 1, 0};
    for (k = 0; k < 12; k++) rd((k < 11) ? 12'h700 + 12'(k) : 12'h7ff, rst_exp[k]);
    wr(12'h700, 32'hffffffff);
    rd(12'h700, REV);
    wr(12'h701, 32'ha5a55a5a);
    rd(12'h701, 32'ha5a55a5a);
    wr(12'h708, 32'hffffffff);
    wr(12'h707, 32'hffffffff);
    rd(12'h708, 32'h0000ffff);
    rd(12'h707, 32'hffffffff);
    $display("register test done");
    n0 = n_notify;
    w0 = n_words;
    u_peer.send(48'hffffffffffff, PF, 8'h04, 0);
    u_peer.send(DA, PF, 8'h04, 0);
    repeat (40) @(posedge clk_sys_in);
    chk(64'(n_notify - n0), 64'h1);
    chk(64'(n_words - w0), 64'h4);
    $display("broadcast test done");
    n0 = n_std;
    u_peer.send(48'hffffffffffff, 32'h88080001, 8'h00, 0);
    wr(12'h70a, 32'h0);
    u_peer.send(48'hffffffffffff, 32'h88080001, 8'h00, 0);
    wr(12'h70a, 32'h1);
    wr(12'h705, 32'hfe);
    u_peer.send(48'hffffffffffff, 32'h88080001, 8'h01, 0);
    repeat (40) @(posedge clk_sys_in);
    chk(64'(n_std - n0), 64'h1);
    chk(64'(std_class_out), 64'h1);
    $display("standard mode test done");
    client_ready_in <= 1'b0;
    w0 = n_words;
    fork
      repeat (6) u_peer.send(DA, PF, 8'h01, 0);
      begin
        for (k = 0; k < 200 && rx_ready_out !== 1'b0; k++) @(posedge clk_sys_in);
        chk(64'(rx_ready_out), 64'h0);
        client_ready_in <= 1'b1;
      end
    join
    repeat (40) @(posedge clk_sys_in);
    chk(64'(n_words - w0), 64'h18);
    $display("buffer test done");
    stop_test();
  end
endmodule
`default_nettype wire
